// File: logic/ior_unit.sv
`timescale 1ns/1ps
`include "ior_defs.svh"

module ior_unit
    import ior_pkg::*;
(
    input  wire logic              i_sys_clk,
    input  wire logic              i_reset_n,
    input  wire logic              i_instr_valid,
    input  wire logic [15:0]       i_instr,
    input  wire logic [3:0]        i_bank_select_register,
    input  wire logic              i_ext_set_en,
    input  wire logic [11:0]       i_index_base,
    input  wire logic [7:0]        i_mem_rdata,
    output logic                   o_busy,
    output logic                   o_done,
    output logic [11:0]            o_mem_raddr,
    output logic                   o_mem_rd,
    output ior_mem_wr_t            o_mem_wr,
    output logic [7:0]             o_wreg,
    output ior_flags_t             o_flags
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        ior_phase_t  phase;
        logic        active;
        ior_dec_t    dec;
        logic [11:0] addr;
        logic [7:0]  operand;
        logic [7:0]  result;
        logic [7:0]  wreg;
        ior_flags_t  flags;
        logic        done;
        ior_mem_wr_t wr;
    } ior_state_t;

    ior_state_t state_q;
    ior_state_t state_d;
    ior_dec_t   dec_now;

    ior_decode u_decode (
        .i_instr (i_instr),
        .o_dec   (dec_now)
    );

    // address forming is used for read and write; kept in one place
    function automatic logic [11:0] form_addr(input ior_dec_t d, input logic [3:0] bank,
                                              input logic ext, input logic [11:0] base);
        logic [11:0] a;
        a = '0;
        if (d.bank_acc) begin
            a = {bank, d.field};
        end else if (ext && d.field <= `IOR_INDEX_LIMIT) begin
            a = base + {4'h0, d.field};
        end else if (d.field <= `IOR_ACC_LOW_LIMIT) begin
            a = {4'h0, d.field};
        end else begin
            a = {`IOR_ACC_HIGH_BANK, d.field};
        end
        return a;
    endfunction

    // ----------------------------------------
    // four-phase sequencer
    // ----------------------------------------
    always_comb begin
        state_d      = state_q;
        state_d.done = 1'b0;
        state_d.wr   = '0;
        case (state_q.phase)
            IOR_Q1: begin
                // decode; only accepted instructions start a cycle
                if (i_instr_valid && (dec_now.is_lit || dec_now.is_file)) begin
                    state_d.active = 1'b1;
                    state_d.dec    = dec_now;
                    state_d.addr   = form_addr(dec_now, i_bank_select_register,
                                               i_ext_set_en, i_index_base);
                    state_d.phase  = IOR_Q2;
                end
            end
            IOR_Q2: begin
                // read literal or register
                state_d.operand = state_q.dec.is_lit ? state_q.dec.field
                                                     : i_mem_rdata;
                state_d.phase   = IOR_Q3;
            end
            IOR_Q3: begin
                state_d.result  = state_q.wreg | state_q.operand;
                state_d.phase   = IOR_Q4;
            end
            IOR_Q4: begin
                state_d.flags.n = state_q.result[7];
                state_d.flags.z = (state_q.result == 8'h00);
                if (state_q.dec.is_file && state_q.dec.dest_file) begin
                    state_d.wr.valid = 1'b1;
                    state_d.wr.addr  = state_q.addr;
                    state_d.wr.data  = state_q.result;
                end else begin
                    state_d.wreg = state_q.result;
                end
                state_d.done   = 1'b1;
                state_d.active = 1'b0;
                state_d.phase  = IOR_Q1;
            end
            default: begin
                state_d.phase  = IOR_Q1;
                state_d.active = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_q       <= '0;
            state_q.phase <= IOR_Q1;
            state_q.wreg  <= `IOR_WREG_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    assign o_busy      = state_q.active;
    assign o_done      = state_q.done;
    assign o_mem_raddr = state_q.addr;
    assign o_mem_rd    = (state_q.phase == IOR_Q2) && state_q.dec.is_file;
    assign o_mem_wr    = state_q.wr;
    assign o_wreg      = state_q.wreg;
    assign o_flags     = state_q.flags;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    lit_result_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (state_q.phase == IOR_Q4 && state_q.dec.is_lit)
        |=> (o_wreg == ($past(state_q.wreg) | $past(state_q.dec.field))))
        else $error("literal or result wrong");

    lit_cycle_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (state_q.phase == IOR_Q1 && i_instr_valid && i_instr[15:8] == 8'h09)
        |-> ##4 o_done)
        else $error("literal op not done in four phases");

    file_dest_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (state_q.phase == IOR_Q4 && state_q.dec.is_file)
        |=> (o_mem_wr.valid == $past(state_q.dec.dest_file)))
        else $error("file op destination wrong");

    file_flags_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        o_done |-> (o_flags.z == ($past(state_q.result) == 8'h00))
                   && (o_flags.n == $past(state_q.result[7])))
        else $error("flags wrong");

    // covers every unbanked access that is not indexed, with the extended set on or off
    access_bank_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (state_q.phase == IOR_Q2 && !state_q.dec.bank_acc
         && !($past(i_ext_set_en) && state_q.dec.field <= `IOR_INDEX_LIMIT))
        |-> (o_mem_raddr == ((state_q.dec.field <= `IOR_ACC_LOW_LIMIT)
                             ? {4'h0, state_q.dec.field}
                             : {`IOR_ACC_HIGH_BANK, state_q.dec.field})))
        else $error("access bank address wrong");

    indexed_addr_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (state_q.phase == IOR_Q1 && i_instr_valid && dec_now.is_file && !dec_now.bank_acc
         && i_ext_set_en && i_instr[7:0] <= 8'h5F)
        |=> (o_mem_raddr == $past(i_index_base) + {4'h0, $past(i_instr[7:0])}))
        else $error("indexed address wrong");

    phase_order_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (state_q.phase == IOR_Q2) |=> (state_q.phase == IOR_Q3) ##1 (state_q.phase == IOR_Q4)
        ##1 (state_q.phase == IOR_Q1 && o_done))
        else $error("phase order wrong");

    banked_addr_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (state_q.phase == IOR_Q1 && i_instr_valid && dec_now.is_file && dec_now.bank_acc)
        |=> (o_mem_raddr == {$past(i_bank_select_register), $past(i_instr[7:0])}))
        else $error("banked address wrong");

    busy_idle_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (state_q.phase == IOR_Q1)
        |-> !o_busy)
        else $error("busy while waiting for decode");

    lit_no_read_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (state_q.phase == IOR_Q2 && state_q.dec.is_lit)
        |-> !o_mem_rd)
        else $error("literal op read data memory");

    lit_no_write_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (state_q.phase == IOR_Q4 && state_q.dec.is_lit)
        |=> !o_mem_wr.valid)
        else $error("literal op wrote data memory");

    file_accum_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (state_q.phase == IOR_Q4 && state_q.dec.is_file && !state_q.dec.dest_file)
        |=> (o_wreg == $past(state_q.result)) && !o_mem_wr.valid)
        else $error("file op accumulator result wrong");

    done_pulse_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        o_done
        |=> !o_done)
        else $error("retire pulse longer than one cycle");

    file_operand_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (state_q.phase == IOR_Q2 && state_q.dec.is_file)
        |=> (state_q.operand == $past(i_mem_rdata)))
        else $error("register operand not taken in read phase");

    // the accumulator may only move in the write phase, never mid-instruction
    wreg_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (state_q.phase != IOR_Q4)
        |=> $stable(o_wreg))
        else $error("accumulator changed outside write phase");

    ignore_foreign_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (state_q.phase == IOR_Q1 && !(i_instr_valid && (dec_now.is_lit || dec_now.is_file)))
        |=> (state_q.phase == IOR_Q1 && !o_busy))
        else $error("foreign opcode started a cycle");

endmodule // ior_unit

// File: logic/ior_defs.svh
`ifndef IOR_DEFS_SVH
`define IOR_DEFS_SVH

// ----------------------------------------
// opcode fields
// ----------------------------------------
`define IOR_LIT_OPCODE    8'h09
`define IOR_FILE_PREFIX   6'h04
`define IOR_PREFIX_MSB    15
`define IOR_PREFIX_LSB    10
`define IOR_DEST_BIT      9
`define IOR_ACC_BIT       8
`define IOR_INDEX_LIMIT   8'h5F
`define IOR_ACC_LOW_LIMIT 8'h5F
`define IOR_ACC_HIGH_BANK 4'hF

// ----------------------------------------
// reset values
// ----------------------------------------
`define IOR_WREG_RESET    8'h00
`define IOR_PHASE_RESET   4'h1

`endif

// File: logic/ior_pkg.sv
package ior_pkg;

    typedef enum logic [3:0] {
        IOR_Q1 = 4'h1,
        IOR_Q2 = 4'h2,
        IOR_Q3 = 4'h4,
        IOR_Q4 = 4'h8
    } ior_phase_t;

    typedef struct packed {
        logic        is_lit;
        logic        is_file;
        logic        dest_file;
        logic        bank_acc;
        logic [7:0]  field;
    } ior_dec_t;

    typedef struct packed {
        logic        valid;
        logic [11:0] addr;
        logic [7:0]  data;
    } ior_mem_wr_t;

    typedef struct packed {
        logic        n;
        logic        z;
    } ior_flags_t;

endpackage

// File: logic/ior_decode.sv
`timescale 1ns/1ps
`include "ior_defs.svh"

module ior_decode
    import ior_pkg::*;
(
    input  wire logic [15:0] i_instr,
    output ior_dec_t         o_dec
);

    always_comb begin
        o_dec           = '0;
        o_dec.is_lit    = (i_instr[15:8] == `IOR_LIT_OPCODE);
        o_dec.is_file   = (i_instr[`IOR_PREFIX_MSB:`IOR_PREFIX_LSB] == `IOR_FILE_PREFIX);
        o_dec.dest_file = i_instr[`IOR_DEST_BIT];
        o_dec.bank_acc  = i_instr[`IOR_ACC_BIT];
        o_dec.field     = i_instr[7:0];
    end

endmodule // ior_decode

// File: dv/tb_inclusive_or_instruction_unit.sv
`timescale 1ns/1ps
module tb_inclusive_or_instruction_unit;
    import ior_pkg::*;
    logic        clk;
    logic        rst_n;
    logic        vld;
    logic        ext;
    logic [15:0] instr;
    logic [3:0]  bank;
    logic [11:0] base;
    logic [11:0] raddr;
    logic [7:0]  rdata;
    logic [7:0]  wreg;
    logic [7:0]  w;
    logic        busy;
    logic        done;
    logic        rd;
    ior_mem_wr_t wr;
    ior_flags_t  fl;
    int          miscompares;
    int          cmp_count;

    ior_unit dut (.i_sys_clk(clk), .i_reset_n(rst_n), .i_instr_valid(vld), .i_instr(instr),
        .i_bank_select_register(bank), .i_ext_set_en(ext), .i_index_base(base),
        .i_mem_rdata(rdata), .o_busy(busy), .o_done(done), .o_mem_raddr(raddr),
        .o_mem_rd(rd), .o_mem_wr(wr), .o_wreg(wreg), .o_flags(fl));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input logic [20:0] got, input logic [20:0] exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask

    // one instruction through all four phases; ea is the expected operand address
    task automatic run(input logic [15:0] ins, input logic [7:0] d, input logic [11:0] ea);
        logic [7:0] res;
        logic       f;
        f   = (ins[15:10] == 6'h04);
        res = w | (f ? d : ins[7:0]);
        @(posedge clk);
        instr <= ins;
        rdata <= d;
        vld   <= 1'b1;
        @(posedge clk);
        vld <= 1'b0;
        #1;
        chk(busy, 21'h1, "busy in second phase");
        if (f) chk({rd, raddr}, {1'b1, ea}, "operand address");
        else chk(rd, 21'h0, "literal reads no register");
        repeat (3) @(posedge clk);
        #1;
        chk({done, busy}, 21'h2, "retire timing");
        if (f && ins[9]) begin
            chk(wr, {1'b1, ea, res}, "register write back");
            chk(wreg, w, "accumulator kept");
        end else begin
            chk(wr.valid, 21'h0, "no register write");
            chk(wreg, res, "accumulator result");
            w = res;
        end
        chk(fl, {res[7], res == 8'h00}, "flags");
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_literal();
        chk({wreg, fl}, 21'h0, "reset state");
        run(16'h0900, 8'h00, 12'h000);
        run(16'h0935, 8'h00, 12'h000);
        run(16'h0980, 8'h00, 12'h000);
        $display("literal test done");
    endtask

    task automatic t_file();
        @(posedge clk);
        bank <= 4'h3;
        run(16'h1112, 8'h42, 12'h312);
        run(16'h1210, 8'h81, 12'h2B0);
        @(posedge clk);
        bank <= 4'hF;
        run(16'h13FF, 8'h00, 12'hFFF);
        run(16'h1060, 8'h08, 12'hF60);
        @(posedge clk);
        ext <= 1'b0;
        run(16'h1220, 8'h11, 12'h020);
        $display("file test done");
    endtask

    // neither opcode: nothing may retire
    task automatic t_ignored();
        @(posedge clk);
        instr <= 16'h0A55;
        vld   <= 1'b1;
        @(posedge clk);
        vld <= 1'b0;
        repeat (6) begin
            @(posedge clk);
            #1;
            chk({done, busy}, 21'h0, "foreign opcode ignored");
        end
        $display("ignore test done");
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        #5000;
        miscompares++;
        print_verdict();
    end

    initial begin
        rst_n = 1'b0;
        vld   = 1'b0;
        ext   = 1'b1;
        instr = 16'h0000;
        bank  = 4'h0;
        base  = 12'h2A0;
        rdata = 8'h00;
        w     = 8'h00;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_literal();
        t_file();
        t_ignored();
        print_verdict();
    end
endmodule // tb_inclusive_or_instruction_unit
